// ==== rtl/spsd_defs.svh ====
`ifndef SPSD_DEFS_SVH
`define SPSD_DEFS_SVH

// direct address space split
`define SPSD_SPACE_BASE     8'h80
`define SPSD_SPACE_BIT      7

// page select register
`define SPSD_PAGE_ADDR      8'hBF
`define SPSD_PAGE_RESET     8'h00
`define SPSD_PAGE_0         8'h00
`define SPSD_PAGE_F         8'h0F

// bit-addressable locations have a low nibble of 0x0 or 0x8
`define SPSD_BIT_MASK       8'h07
`define SPSD_BIT_MATCH      8'h00

// locations that hold a different register on each page
`define SPSD_PS_CLKMUL      8'hB9
`define SPSD_PS_ITCF        8'hE4
`define SPSD_PS_T34_LO      8'h91
`define SPSD_PS_T34_HI      8'h95
`define SPSD_PS_SMB_LO      8'hC0
`define SPSD_PS_SMB_HI      8'hC2
`define SPSD_PS_T25_CN      8'hC8
`define SPSD_PS_T25_LO      8'hCA
`define SPSD_PS_T25_HI      8'hCF

// unoccupied locations in the special register space
`define SPSD_RSV_0          8'h96
`define SPSD_RSV_1          8'h97
`define SPSD_RSV_2          8'hAB
`define SPSD_RSV_3          8'hAD
`define SPSD_RSV_4          8'hD7

`endif

// ==== rtl/spsd_pkg.sv ====
`include "spsd_defs.svh"

package spsd_pkg;

    // class of a direct-addressed location under the current page
    typedef enum logic [2:0] {
        SPSD_CL_MEM,
        SPSD_CL_PAGEREG,
        SPSD_CL_SHARED,
        SPSD_CL_PAGE0,
        SPSD_CL_PAGEF,
        SPSD_CL_NONE
    } spsd_class_t;

    // one access from the core
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       bit_op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spsd_req_t;

    // access forwarded to the special registers
    typedef struct packed {
        logic       sel;
        logic       page_f;
        logic       rd;
        logic       wr;
        logic       bit_op;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spsd_tgt_t;

    // access forwarded to ordinary data memory
    typedef struct packed {
        logic       sel;
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spsd_mem_t;

    function automatic logic spsd_is_special(input logic [7:0] a);
        return a[`SPSD_SPACE_BIT];
    endfunction

    function automatic logic spsd_is_bit_addr(input logic [7:0] a);
        return (a & `SPSD_BIT_MASK) == `SPSD_BIT_MATCH;
    endfunction

    function automatic logic spsd_is_page_specific(input logic [7:0] a);
        return (a == `SPSD_PS_CLKMUL) || (a == `SPSD_PS_ITCF) || (a == `SPSD_PS_T25_CN)
            || ((a >= `SPSD_PS_T34_LO) && (a <= `SPSD_PS_T34_HI))
            || ((a >= `SPSD_PS_SMB_LO) && (a <= `SPSD_PS_SMB_HI))
            || ((a >= `SPSD_PS_T25_LO) && (a <= `SPSD_PS_T25_HI));
    endfunction

    function automatic logic spsd_is_reserved(input logic [7:0] a);
        return (a == `SPSD_RSV_0) || (a == `SPSD_RSV_1) || (a == `SPSD_RSV_2)
            || (a == `SPSD_RSV_3) || (a == `SPSD_RSV_4);
    endfunction

endpackage

// ==== rtl/spsd_decode.sv ====
`timescale 1ns/10ps

`include "spsd_defs.svh"

module spsd_decode
    import spsd_pkg::*;
(
    input  wire logic [7:0]  addr,    // direct address of the access
    input  wire logic [7:0]  page,    // current page select value
    input  wire logic        bit_op,  // single-bit access
    output spsd_class_t      cls,     // where the access lands
    output logic             bit_bad  // bit access on a byte-only location
);

    // classify the location; page-specific slots follow the page value
    always_comb begin
        bit_bad = 1'b0;
        if (!spsd_is_special(addr)) begin
            cls = SPSD_CL_MEM;
        end else if (addr == `SPSD_PAGE_ADDR) begin
            cls = SPSD_CL_PAGEREG;
        end else if (spsd_is_reserved(addr)) begin
            cls = SPSD_CL_NONE;
        end else if (spsd_is_page_specific(addr)) begin
            if (page == `SPSD_PAGE_F) begin
                cls = SPSD_CL_PAGEF;
            end else if (page == `SPSD_PAGE_0) begin
                cls = SPSD_CL_PAGE0;
            end else begin
                cls = SPSD_CL_NONE;
            end
        end else begin
            cls = SPSD_CL_SHARED;
        end
        // bit access only exists for special locations ending in 0x0 or 0x8
        if (bit_op && spsd_is_special(addr) && !spsd_is_bit_addr(addr)) begin
            bit_bad = 1'b1;
        end
    end

endmodule

// ==== rtl/spsd_top.sv ====
`timescale 1ns/10ps

`include "spsd_defs.svh"

// Contract
// - an 8-bit read/write page select register clears to zero on reset and picks the page.
// - writing the page select register replaces the page for all later accesses.
// - reading the page select register returns the full current page byte.
// - the page select register answers at 0xBF whatever the current page is.
// - special locations ending in 0x0 or 0x8 also take bit accesses; all others take bytes only.
// - a register not tied to one page is mapped the same on page 0 and page F.
// - only pages 0x0 and 0xF exist within the eight-bit page number.
// - direct accesses to 0x80 through 0xFF go to the special registers, not data memory.

module spsd_top
    import spsd_pkg::*;
(
    input  wire logic        clk_sys,   // system clock, 10 MHz
    input  wire logic        arst_n,    // asynchronous reset, active low
    input  wire spsd_req_t   req,       // direct access from the core
    output spsd_tgt_t        tgt,       // forwarded special register access
    output spsd_mem_t        mem,       // forwarded data memory access
    output logic [7:0]       page,      // page select register
    output logic [7:0]       rd_data,   // read data of the page register
    output logic             rd_valid,  // rd_data holds a fresh answer
    output logic             acc_err    // refused access, one-cycle pulse
);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic        rst_meta;
    logic        rst_n;

    // assert at once, release two edges later so no flop sees a ragged edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    spsd_class_t cls;
    logic        bit_bad;
    logic        req_any;
    logic        page_wr;
    logic        page_rd;

    spsd_decode u_decode (
        .addr    (req.addr),
        .page    (page),
        .bit_op  (req.bit_op),
        .cls     (cls),
        .bit_bad (bit_bad)
    );

    // a write wins if the core ever raises both strobes together
    assign req_any = req.rd | req.wr;
    assign page_wr = req.wr && !bit_bad && (cls == SPSD_CL_PAGEREG);
    assign page_rd = req.rd && !req.wr && !bit_bad && (cls == SPSD_CL_PAGEREG);

    ////////////////////////////////////////////////////////////////////////
    // page select register

    // decode uses the old page this cycle; the new one steers the next access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page <= `SPSD_PAGE_RESET;
        end else if (page_wr) begin
            page <= req.wdata;
        end
    end

    // read answer of the page register, a full byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= `SPSD_PAGE_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= page_rd;
            if (page_rd) begin
                rd_data <= page;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // special register forwarding

    // the page bit only matters for page-specific slots; shared slots see zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tgt <= '0;
        end else begin
            tgt.sel     <= 1'b0;
            tgt.page_f  <= 1'b0;
            tgt.rd      <= 1'b0;
            tgt.wr      <= 1'b0;
            tgt.bit_op  <= 1'b0;
            tgt.bit_idx <= req.bit_idx;
            tgt.addr    <= req.addr;
            tgt.wdata   <= req.wdata;
            if (req_any && !bit_bad) begin
                if (cls == SPSD_CL_SHARED || cls == SPSD_CL_PAGE0
                        || cls == SPSD_CL_PAGEF) begin
                    tgt.sel    <= 1'b1;
                    tgt.page_f <= (cls == SPSD_CL_PAGEF);
                    tgt.rd     <= req.rd && !req.wr;
                    tgt.wr     <= req.wr;
                    tgt.bit_op <= req.bit_op;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory forwarding

    // only the lower half of the direct space is ordinary memory
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem <= '0;
        end else begin
            mem.sel   <= req_any && (cls == SPSD_CL_MEM);
            mem.rd    <= req.rd && !req.wr && (cls == SPSD_CL_MEM);
            mem.wr    <= req.wr && (cls == SPSD_CL_MEM);
            mem.addr  <= req.addr;
            mem.wdata <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // refused accesses

    // flagged only as a debug aid; software must not lean on these slots anyway
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_err <= 1'b0;
        end else begin
            acc_err <= req_any && (bit_bad || cls == SPSD_CL_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_page_write_takes: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr == `SPSD_PAGE_ADDR)
            |=> (page == $past(req.wdata)) && !tgt.sel
    ) else $error("page write did not take the written byte");

    a_page_read_back: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.rd && !req.wr && !req.bit_op && req.addr == `SPSD_PAGE_ADDR)
            |=> rd_valid && (rd_data == $past(page))
    ) else $error("page read did not return the current page");

    a_page_any_page: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && !req.bit_op && req.addr == `SPSD_PAGE_ADDR && page != `SPSD_PAGE_0
            && page != `SPSD_PAGE_F) |=> (page == $past(req.wdata))
    ) else $error("page register unreachable from an odd page");

    a_page_held_still: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(req.wr && req.addr == `SPSD_PAGE_ADDR) |=> $stable(page)
    ) else $error("page changed without a write");

    a_bit_op_refused: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && req.bit_op && req.addr[7] && req.addr[2:0] != 3'h0)
            |=> acc_err && !tgt.sel && !mem.sel
    ) else $error("bit access on a byte-only location was not refused");

    a_bit_op_passed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.wr && req.bit_op && req.addr == 8'h88) |=> tgt.sel && tgt.bit_op && tgt.wr
    ) else $error("bit access on a bit location was dropped");

    a_shared_same_map: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req.rd && !req.wr && !req.bit_op && req.addr == 8'hE0)
            |=> tgt.sel && !tgt.page_f && tgt.rd && tgt.addr == 8'hE0
    ) else $error("shared location did not map identically");

    a_page_f_route: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && !req.bit_op && req.addr == 8'hC1 && page == `SPSD_PAGE_F)
            |=> tgt.sel && tgt.page_f
    ) else $error("page F slot not routed to page F");

    a_page_0_route: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && !req.bit_op && req.addr == 8'hC1 && page == `SPSD_PAGE_0)
            |=> tgt.sel && !tgt.page_f
    ) else $error("page 0 slot not routed to page 0");

    a_odd_page_none: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && !req.bit_op && req.addr == 8'h91 && page != `SPSD_PAGE_0
            && page != `SPSD_PAGE_F) |=> !tgt.sel && acc_err
    ) else $error("unimplemented page reached a page-specific slot");

    a_low_to_mem: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && !req.addr[7]) |=> mem.sel && !tgt.sel && !acc_err
    ) else $error("lower direct address not sent to memory");

    a_high_not_mem: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (req_any && req.addr[7]) |=> !mem.sel
    ) else $error("upper direct address leaked to memory");

endmodule

// ==== test/spsd_core_model.sv ====
`timescale 1ns/10ps

module spsd_core_model
    import spsd_pkg::*;
(
    input  wire logic clk_sys, // system clock
    output spsd_req_t req      // access toward the decoder
);
    spsd_req_t last;

    // bus starts quiet
    initial begin
        req  = '0;
        last = '0;
    end

    // one access for one cycle, entered at a falling edge, left at the next one, so a
    // following access starts at once with no second assignment; reserved slots are
    // reached only when a caller wants to see a refusal
    task automatic access(input logic rd, input logic wr, input logic bit_op,
                          input logic [2:0] idx, input logic [7:0] addr,
                          input logic [7:0] wdata);
        req  = '{rd: rd, wr: wr, bit_op: bit_op, bit_idx: idx, addr: addr, wdata: wdata};
        last = req;
        @(negedge clk_sys);
    endtask

    // released bus shows the inverse of the last value, so stale sampling cannot pass
    task automatic idle();
        req = '{rd: 1'b0, wr: 1'b0, bit_op: 1'b0, bit_idx: ~last.bit_idx,
                addr: ~last.addr, wdata: ~last.wdata};
        @(negedge clk_sys);
    endtask
endmodule

// ==== test/spsd_tb.sv ====
`timescale 1ns/10ps

module spsd_tb;
    import spsd_pkg::*;

    logic       clk_sys;
    logic       arst_n;
    spsd_req_t  req;
    spsd_tgt_t  tgt;
    spsd_mem_t  mem;
    logic [7:0] page;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       acc_err;
    int         err_total;
    int         check_count;
    logic [7:0] shared_list [7] = '{8'h81, 8'h98, 8'hC3, 8'hC9, 8'hE0, 8'hE5, 8'hFF};
    logic [7:0] rsv_list [5]    = '{8'h96, 8'h97, 8'hAB, 8'hAD, 8'hD7};
    logic [7:0] pg_list [2]     = '{8'h00, 8'h0F};

    spsd_core_model core (.clk_sys(clk_sys), .req(req));

    spsd_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .tgt(tgt), .mem(mem),
                  .page(page), .rd_data(rd_data), .rd_valid(rd_valid), .acc_err(acc_err));

    // free-running 10 MHz clock
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    // one access, then {tgt sel, page_f, mem sel, refused} one cycle later
    task automatic acc(input logic wr, input logic bit_op, input logic [7:0] addr,
                       input logic [7:0] wdata, input logic [3:0] exp);
        core.access(~wr, wr, bit_op, 3'h5, addr, wdata);
        chk({4'h0, tgt.sel, tgt.page_f, mem.sel, acc_err}, {4'h0, exp});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence; inputs move only at falling edges
    initial begin
        err_total   = 0;
        check_count = 0;
        arst_n      = 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(page, 8'h00);
        acc(1'b0, 1'b0, 8'hBF, 8'h00, 4'h0);
        chk({7'h0, rd_valid}, 8'h01);
        chk(rd_data, 8'h00);
        acc(1'b0, 1'b0, 8'hC1, 8'h00, 4'b1000);
        chk(tgt.addr, 8'hC1);
        // page write followed at once by a page-specific read
        acc(1'b1, 1'b0, 8'hBF, 8'h0F, 4'h0);
        chk(page, 8'h0F);
        acc(1'b0, 1'b0, 8'hC1, 8'h00, 4'b1100);
        chk({7'h0, tgt.rd}, 8'h01);
        acc(1'b0, 1'b0, 8'hBF, 8'h00, 4'h0);
        chk(rd_data, 8'h0F);
        // shared slots land the same way on both pages
        foreach (pg_list[p]) begin
            acc(1'b1, 1'b0, 8'hBF, pg_list[p], 4'h0);
            foreach (shared_list[i]) begin
                acc(1'b0, 1'b0, shared_list[i], 8'h00, 4'b1000);
                chk(tgt.addr, shared_list[i]);
            end
        end
        // edge of the special space
        acc(1'b1, 1'b0, 8'h7F, 8'h5A, 4'b0010);
        chk({7'h0, mem.wr}, 8'h01);
        chk(mem.wdata, 8'h5A);
        chk(mem.addr, 8'h7F);
        acc(1'b1, 1'b0, 8'h80, 8'h5A, 4'b1000);
        chk(tgt.wdata, 8'h5A);
        chk({6'h0, tgt.wr, tgt.rd}, 8'h02);
        acc(1'b0, 1'b0, 8'h30, 8'h00, 4'b0010);
        chk({6'h0, mem.wr, mem.rd}, 8'h01);
        // every bit-addressable slot on page F; C0 and C8 are page-specific
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, 1'b1, 8'h80 + 8'(i * 8), 8'h00,
                {1'b1, (i == 8 || i == 9), 2'b00});
            chk({4'h0, tgt.bit_op, tgt.bit_idx}, 8'h0D);
        end
        acc(1'b1, 1'b1, 8'h81, 8'h00, 4'b0001);
        acc(1'b1, 1'b1, 8'h8F, 8'h00, 4'b0001);
        acc(1'b1, 1'b1, 8'hBF, 8'h33, 4'b0001);
        chk(page, 8'h0F);
        // a page number outside the two pages is kept whole
        acc(1'b1, 1'b0, 8'hBF, 8'hA5, 4'h0);
        chk(page, 8'hA5);
        acc(1'b0, 1'b0, 8'hBF, 8'h00, 4'h0);
        chk(rd_data, 8'hA5);
        acc(1'b0, 1'b0, 8'hC1, 8'h00, 4'b0001);
        acc(1'b0, 1'b0, 8'h91, 8'h00, 4'b0001);
        acc(1'b0, 1'b0, 8'h81, 8'h00, 4'b1000);
        foreach (rsv_list[i]) begin
            acc(1'b0, 1'b0, rsv_list[i], 8'h00, 4'b0001);
        end
        // the page register stays reachable while an unimplemented page is selected
        acc(1'b1, 1'b0, 8'hBF, 8'h0F, 4'h0);
        chk(page, 8'h0F);
        // both strobes at once count as a write, so no read answer follows
        core.access(1'b1, 1'b1, 1'b0, 3'h0, 8'hBF, 8'h3C);
        chk({7'h0, rd_valid}, 8'h00);
        chk(page, 8'h3C);
        core.idle();
        chk({5'h0, tgt.sel, mem.sel, acc_err}, 8'h00);
        // reset in mid-run clears the page again
        arst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(page, 8'h00);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        acc(1'b0, 1'b0, 8'hBF, 8'h00, 4'h0);
        chk(rd_data, 8'h00);
        core.idle();
        final_report();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule
